// ---- hw/i2c_control_status_regs.sv ----
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "twi_ctl_regs.svh"

// Functional notes
// - with ack enabled, receiver pulls data low in ack slot; transmitter releases
// - source select bit picks clock/16 when clear, clock/512 when set
// - interrupt enable bit: clear disables, set enables the transfer interrupt
// - pending flag reads 1 while pending; software can only clear it
// - while pending, clock line held low; writing 0 clears and resumes; the code releases the clock line when arbitration loss sets pending
// - pending set on byte done, address match or general call, arbitration loss
// - serial rate is selected source divided by prescaler plus one
// - mode field: 00 slave rx, 01 slave tx, 10 master rx, 11 master tx
// - busy bit reads 1 while bus busy, 0 while free
// - writing busy bit 1 starts and sends data byte; 0 issues stop
// - serial output enable gates all bus activity
// - arbitration flag reads 1 after arbitration loss, else 0
// - own-address flag set on match, cleared on start or stop
// - address-zero flag set on general call, cleared on start or stop
// - last-bit flag holds ack slot value: 0 ack, 1 no ack
// - status resets to zero; control flag bits reset to zero
// - own slave address writable only with serial output disabled
// - data shift register writable only with serial output enabled
module i2c_control_status_regs
  import twi_ctl_pkg::*;
(
  input  wire logic        core_clk_i,       // peripheral clock, 10 MHz
  input  wire logic        rst_b_i,          // async reset, active low
  input  wire logic [31:0] avs_address_i,    // byte address
  input  wire logic        avs_read_i,       // read request
  input  wire logic        avs_write_i,      // write request
  input  wire logic [31:0] avs_writedata_i,  // write data, low byte used
  output logic      [31:0] avs_readdata_o,   // read data
  output logic             avs_waitrequest_o,// stall while high
  input  wire logic        scl_i,            // clock line level
  output logic             scl_o,            // clock line drive value
  output logic             scl_oe_o,         // clock line pulled low
  input  wire logic        sda_i,            // data line level
  output logic             sda_o,            // data line drive value
  output logic             sda_oe_o,         // data line pulled low
  output logic             irq_o             // transfer interrupt request
);

  // edge watch starts at idle line level, so no false edge follows reset
  localparam ctl_state_s RESET_STATE = '{st: ST_IDLE, pre: `CON_PRE_RESET, scl_q: 1'b1,
                                         sda_q: 1'b1, default: '0};

  ctl_state_s s;
  ctl_state_s next_s;
  logic       scl_s;
  logic       sda_s;
  logic       tick;
  logic       run;

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {SEL_NONE, SEL_CON, SEL_STAT, SEL_OWN, SEL_DATA} sel_e;

  function automatic sel_e reg_sel(input logic [31:0] addr);
    case (addr)
      `BUS_CONTROL_ADDR:        reg_sel = SEL_CON;
      `BUS_CONTROL_STATUS_ADDR: reg_sel = SEL_STAT;
      `OWN_SLAVE_ADDRESS_ADDR:  reg_sel = SEL_OWN;
      `DATA_SHIFT_REG_ADDR:     reg_sel = SEL_DATA;
      default:                  reg_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] read_mux(input sel_e sel, input ctl_state_s r);
    case (sel)
      SEL_CON:  read_mux = {r.ack_en, r.clk_sel, r.int_en, r.pend, r.pre};
      SEL_STAT: read_mux = {r.mode, r.busy, r.out_en, r.arb, r.match, r.zero, r.last};
      SEL_OWN:  read_mux = r.own;
      SEL_DATA: read_mux = r.data;
      default:  read_mux = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // line input and bit-rate divider
  // ---------------------------------------------------------------------------
  line_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_o      (scl_s),
    .sda_o      (sda_s)
  );

  assign run = (s.st != ST_IDLE) && (s.st != ST_HOLD) && (s.st != ST_SLAVE);

  bit_rate_div u_div (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .run_i      (run),
    .clk_sel_i  (s.clk_sel),
    .pre_i      (s.pre),
    .tick_o     (tick)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic       req;
  logic       commit;
  sel_e       sel;
  logic [7:0] wd;
  logic       go;
  logic       rise;
  logic       fall;
  logic       start_det;
  logic       stop_det;
  logic       tx_now;
  logic       addressed;
  logic       hit;
  logic       gcall;

  always_comb begin
    next_s    = s;
    req       = avs_read_i | avs_write_i;
    commit    = req & s.rsp;
    sel       = reg_sel(avs_address_i);
    wd        = avs_writedata_i[7:0];
    go        = 1'b0;
    rise      = scl_s & ~s.scl_q;
    fall      = ~scl_s & s.scl_q;
    start_det = scl_s & s.scl_q & s.sda_q & ~sda_s;
    stop_det  = scl_s & s.scl_q & ~s.sda_q & sda_s;
    tx_now    = s.first | s.mode[`MODE_TX_BIT];
    addressed = s.match | s.zero;
    hit       = (s.data[7:1] == s.own[7:1]);
    gcall     = (s.data[7:1] == `GENERAL_CALL);

    // bus slave: one wait cycle, then commit
    next_s.rsp = req & ~s.rsp;
    if (req & ~s.rsp & avs_read_i) begin
      next_s.rdata = read_mux(sel, s);
    end

    // software writes
    if (commit & avs_write_i) begin
      case (sel)
        SEL_CON: begin
          next_s.ack_en  = wd[`CON_ACK_BIT];
          next_s.clk_sel = wd[`CON_CLKSEL_BIT];
          next_s.int_en  = wd[`CON_INTEN_BIT];
          next_s.pre     = wd[`CON_PRE_MSB:`CON_PRE_LSB];
          if (!wd[`CON_PEND_BIT]) begin
            next_s.pend = 1'b0;
          end
        end
        SEL_STAT: begin
          next_s.mode   = wd[`STAT_MODE_MSB:`STAT_MODE_LSB];
          next_s.out_en = wd[`STAT_OUTEN_BIT];
          if (wd[`STAT_BUSY_BIT]) begin
            go = wd[`STAT_OUTEN_BIT] & wd[`STAT_MODE_MSB] & ~s.busy;
          end else if (s.master) begin
            next_s.stop_req = 1'b1;
          end
        end
        SEL_OWN: begin
          if (!s.out_en) begin
            next_s.own = wd;
          end
        end
        SEL_DATA: begin
          if (s.out_en) begin
            next_s.data = wd;
          end
        end
        default: begin
        end
      endcase
    end

    // line watch
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    if (start_det | stop_det) begin
      next_s.match = 1'b0;
      next_s.zero  = 1'b0;
    end
    if (!s.master & start_det) begin
      next_s.busy = 1'b1;
    end
    if (!s.master & stop_det) begin
      next_s.busy = 1'b0;
    end

    // byte engine; later pending sets win over a software clear
    if (!next_s.out_en) begin
      next_s.st      = ST_IDLE;
      next_s.scl_low = 1'b0;
      next_s.sda_low = 1'b0;
      next_s.master  = 1'b0;
    end else begin
      case (s.st)
        ST_IDLE: begin
          if (go) begin
            next_s.st       = ST_START;
            next_s.sda_low  = 1'b1;
            next_s.master   = 1'b1;
            next_s.busy     = 1'b1;
            next_s.arb      = 1'b0;
            next_s.first    = 1'b1;
            next_s.cnt      = 4'h0;
            next_s.stop_req = 1'b0;
          end else if (start_det & ~s.mode[`MODE_MASTER_BIT]) begin
            next_s.st     = ST_SLAVE;
            next_s.cnt    = 4'h0;
            next_s.first  = 1'b1;
            next_s.ack_ph = 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            next_s.scl_low = 1'b1;
            next_s.st      = ST_LOW;
          end
        end
        ST_LOW: begin
          if (s.cnt < `BYTE_BITS) begin
            next_s.sda_low = tx_now & ~s.data[7];
          end else begin
            next_s.sda_low = ~tx_now & s.ack_en;
          end
          if (tick) begin
            next_s.scl_low = 1'b0;
            next_s.st      = ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            if (s.cnt < `BYTE_BITS) begin
              if (tx_now & s.data[7] & ~sda_s) begin
                next_s.arb     = 1'b1;
                next_s.pend    = 1'b1;
                next_s.master  = 1'b0;
                next_s.mode    = `MODE_SLAVE_RX;
                next_s.scl_low = 1'b0;
                next_s.sda_low = 1'b0;
                next_s.st      = ST_IDLE;
              end else begin
                next_s.data    = {s.data[6:0], sda_s};
                next_s.cnt     = s.cnt + 4'h1;
                next_s.scl_low = 1'b1;
                next_s.st      = ST_LOW;
              end
            end else begin
              next_s.last    = sda_s;
              next_s.pend    = 1'b1;
              next_s.scl_low = 1'b1;
              next_s.sda_low = 1'b0;
              next_s.st      = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          next_s.scl_low = 1'b1;
          if (!s.pend) begin
            if (s.stop_req) begin
              next_s.sda_low = 1'b1;
              next_s.st      = ST_STOP_A;
            end else begin
              next_s.cnt   = 4'h0;
              next_s.first = 1'b0;
              next_s.st    = ST_LOW;
            end
          end
        end
        ST_STOP_A: begin
          if (tick) begin
            next_s.scl_low = 1'b0;
            next_s.st      = ST_STOP_B;
          end
        end
        ST_STOP_B: begin
          if (tick) begin
            next_s.sda_low  = 1'b0;
            next_s.busy     = 1'b0;
            next_s.master   = 1'b0;
            next_s.stop_req = 1'b0;
            next_s.st       = ST_IDLE;
          end
        end
        ST_SLAVE: begin
          next_s.scl_low = s.pend;
          if (stop_det) begin
            next_s.st      = ST_IDLE;
            next_s.sda_low = 1'b0;
            next_s.scl_low = 1'b0;
          end else if (start_det) begin
            next_s.cnt     = 4'h0;
            next_s.first   = 1'b1;
            next_s.ack_ph  = 1'b0;
            next_s.sda_low = 1'b0;
          end else if (rise) begin
            if (s.ack_ph) begin
              next_s.last = sda_s;
            end else if (s.cnt < `BYTE_BITS) begin
              next_s.data = {s.data[6:0], sda_s};
              next_s.cnt  = s.cnt + 4'h1;
            end
          end else if (fall) begin
            if (s.ack_ph) begin
              next_s.ack_ph  = 1'b0;
              next_s.cnt     = 4'h0;
              next_s.first   = 1'b0;
              next_s.sda_low = addressed & s.mode[`MODE_TX_BIT] & ~s.data[7];
            end else if (s.cnt == `BYTE_BITS) begin
              next_s.ack_ph = 1'b1;
              if (s.first) begin
                next_s.match = hit;
                next_s.zero  = gcall;
                if (hit | gcall) begin
                  next_s.pend               = 1'b1;
                  next_s.mode[`MODE_TX_BIT] = hit & s.data[0];
                  next_s.sda_low            = s.ack_en;
                end
              end else if (addressed) begin
                next_s.pend    = 1'b1;
                next_s.sda_low = ~s.mode[`MODE_TX_BIT] & s.ack_en;
              end else begin
                next_s.sda_low = 1'b0;
              end
            end else if (addressed & s.mode[`MODE_TX_BIT]) begin
              next_s.sda_low = ~s.data[7];
            end
          end
        end
        default: begin
          next_s.st = ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign avs_readdata_o    = {`READ_PAD, s.rdata};
  assign avs_waitrequest_o = req & ~s.rsp;
  assign scl_o             = 1'b0;
  assign scl_oe_o          = s.scl_low;
  assign sda_o             = 1'b0;
  assign sda_oe_o          = s.sda_low;
  assign irq_o             = s.pend & s.int_en;

endmodule

// ---- hw/twi_ctl_regs.svh ----
`ifndef TWI_CTL_REGS_SVH
`define TWI_CTL_REGS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define BUS_CONTROL_ADDR        32'h5400_0000
`define BUS_CONTROL_STATUS_ADDR 32'h5400_0004
`define OWN_SLAVE_ADDRESS_ADDR  32'h5400_0008
`define DATA_SHIFT_REG_ADDR     32'h5400_000C

// ----------------------------------------------------------------------------
// bus_control fields
// ----------------------------------------------------------------------------
`define CON_ACK_BIT     7
`define CON_CLKSEL_BIT  6
`define CON_INTEN_BIT   5
`define CON_PEND_BIT    4
`define CON_PRE_MSB     3
`define CON_PRE_LSB     0
`define CON_PRE_RESET   4'hF

// ----------------------------------------------------------------------------
// bus_control_status fields
// ----------------------------------------------------------------------------
`define STAT_MODE_MSB   7
`define STAT_MODE_LSB   6
`define STAT_BUSY_BIT   5
`define STAT_OUTEN_BIT  4
`define STAT_ARB_BIT    3
`define STAT_MATCH_BIT  2
`define STAT_ZERO_BIT   1
`define STAT_LAST_BIT   0
`define MODE_MASTER_BIT 1
`define MODE_TX_BIT     0
`define MODE_SLAVE_RX   2'h0

// ----------------------------------------------------------------------------
// timing and framing
// ----------------------------------------------------------------------------
`define DIV16_HALF_LAST  8'h07
`define DIV512_HALF_LAST 8'hFF
`define BYTE_BITS        4'h8
`define GENERAL_CALL     7'h00
`define READ_PAD         24'h00_0000

`endif

// ---- hw/twi_ctl_pkg.sv ----
package twi_ctl_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD, ST_STOP_A, ST_STOP_B, ST_SLAVE
  } eng_state_e;

  typedef struct packed {
    eng_state_e  st;
    logic        ack_en;
    logic        clk_sel;
    logic        int_en;
    logic        pend;
    logic [3:0]  pre;
    logic [1:0]  mode;
    logic        busy;
    logic        out_en;
    logic        arb;
    logic        match;
    logic        zero;
    logic        last;
    logic [7:0]  own;
    logic [7:0]  data;
    logic [3:0]  cnt;
    logic        first;
    logic        ack_ph;
    logic        stop_req;
    logic        master;
    logic        scl_low;
    logic        sda_low;
    logic        scl_q;
    logic        sda_q;
    logic        rsp;
    logic [7:0]  rdata;
  } ctl_state_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] pcnt;
  } div_state_s;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_state_s;

endpackage

// ---- hw/line_sync.sv ----
`timescale 1ns/1ps
`include "twi_ctl_regs.svh"

module line_sync
  import twi_ctl_pkg::*;
(
  input  wire logic core_clk_i, // peripheral clock
  input  wire logic rst_b_i,    // async reset, active low
  input  wire logic scl_i,      // clock line level from pin
  input  wire logic sda_i,      // data line level from pin
  output logic      scl_o,      // synchronised clock line
  output logic      sda_o       // synchronised data line
);

  sync_state_s s;
  sync_state_s next_s;

  // ---------------------------------------------------------------------------
  // two-flop synchroniser, idle lines high
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.meta   = {scl_i, sda_i};
    next_s.stable = s.meta;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      s <= next_s;
    end
  end

  assign scl_o = s.stable[1];
  assign sda_o = s.stable[0];

endmodule

// ---- hw/bit_rate_div.sv ----
`timescale 1ns/1ps
`include "twi_ctl_regs.svh"

module bit_rate_div
  import twi_ctl_pkg::*;
(
  input  wire logic       core_clk_i, // peripheral clock
  input  wire logic       rst_b_i,    // async reset, active low
  input  wire logic       run_i,      // count while high, else restart
  input  wire logic       clk_sel_i,  // 0: clock/16 source, 1: clock/512
  input  wire logic [3:0] pre_i,      // prescaler value
  output logic            tick_o      // one pulse per half serial period
);

  div_state_s s;
  div_state_s next_s;
  logic [7:0] src_last;
  logic       src_end;

  // ---------------------------------------------------------------------------
  // source clock, then divide by prescaler plus one
  // ---------------------------------------------------------------------------
  always_comb begin
    src_last = clk_sel_i ? `DIV512_HALF_LAST : `DIV16_HALF_LAST;
    src_end  = (s.cnt == src_last);
    tick_o   = run_i & src_end & (s.pcnt == pre_i);
    next_s   = s;
    if (!run_i) begin
      next_s = '0;
    end else if (src_end) begin
      next_s.cnt  = '0;
      next_s.pcnt = (s.pcnt == pre_i) ? 4'h0 : s.pcnt + 4'h1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// ---- tb/twi_ctl_monitor.sv ----
`timescale 1ns/1ps
`include "twi_ctl_regs.svh"

module twi_ctl_monitor (
  input wire logic        core_clk_i,        // clock
  input wire logic        rst_b_i,           // reset, active low
  input wire logic [31:0] avs_address_i,     // address
  input wire logic        avs_read_i,        // read
  input wire logic        avs_write_i,       // write
  input wire logic [31:0] avs_writedata_i,   // write data
  input wire logic        avs_waitrequest_o, // stall
  input wire logic        scl_oe_o,          // clock line pull
  input wire logic        sda_oe_o,          // data line pull
  input wire logic        irq_o              // interrupt
);
  logic       wr_ok;
  logic       con_wr;
  logic       stat_wr;
  logic       scl_prev;
  logic [7:0] run;
  assign wr_ok   = avs_write_i && !avs_waitrequest_o;
  assign con_wr  = wr_ok && avs_address_i == `BUS_CONTROL_ADDR;
  assign stat_wr = wr_ok && avs_address_i == `BUS_CONTROL_STATUS_ADDR;
  // ----------------------------------------------------------------
  // cycles since the clock line drive last changed
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_prev <= 1'b0;
      run <= 8'h00;
    end else begin
      scl_prev <= scl_oe_o;
      run <= (scl_oe_o != scl_prev) ? 8'h00 : ((run == 8'hFF) ? run : run + 8'h01);
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest longer than one cycle");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && !scl_oe_o && !sda_oe_o)
    else $error("outputs active after reset");
  a_irq_holds_scl: assert property (irq_o && scl_oe_o && !wr_ok |=> scl_oe_o)
    else $error("clock line released while pending");
  a_pend_sticks: assert property (irq_o && !wr_ok |=> irq_o)
    else $error("pending dropped without software");
  a_clr_drops: assert property (con_wr && !avs_writedata_i[4] |=> !irq_o)
    else $error("pending not cleared by write 0");
  a_set_blocked: assert property (con_wr && avs_writedata_i[5:4] == 2'b11 && !irq_o
    && !scl_oe_o && !sda_oe_o |=> !irq_o) else $error("pending set by software");
  a_outen_release: assert property (stat_wr && !avs_writedata_i[4]
    |-> ##[1:2] (!scl_oe_o && !sda_oe_o)) else $error("lines held with output off");
  a_start_first: assert property (stat_wr && avs_writedata_i[7] && avs_writedata_i[5]
    && avs_writedata_i[4] && !scl_oe_o && !sda_oe_o |-> ##[1:2] (sda_oe_o && !scl_oe_o) [*8])
    else $error("start condition malformed");
  a_half_min: assert property ($rose(scl_oe_o) |-> run >= 8'h10)
    else $error("serial half period too short");
endmodule

bind i2c_control_status_regs twi_ctl_monitor u_mon (.core_clk_i, .rst_b_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .scl_oe_o, .sda_oe_o, .irq_o);

// ---- tb/twi_slave_model.sv ----
`timescale 1ns/1ps

module twi_slave_model (
  input  wire logic core_clk_i, // clock
  input  wire logic rst_b_i,    // reset, active low
  input  wire logic scl_i,      // clock line level
  input  wire logic sda_i,      // data line level
  input  wire logic ack_i,      // acknowledge bytes
  input  wire logic jam_i,      // hold data line low
  output logic      sda_oe_o    // pulls data line low
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  // counts clock falls; ninth low phase is the ack slot
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (scl_q && scl_i && sda_q && !sda_i)
        bit_cnt <= 4'h0;
      else if (scl_q && !scl_i)
        bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
    end
  end
  assign sda_oe_o = jam_i || (ack_i && bit_cnt == 4'h9);
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "twi_ctl_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end

module tb_top;
  localparam logic [31:0] con_a  = `BUS_CONTROL_ADDR;
  localparam logic [31:0] stat_a = `BUS_CONTROL_STATUS_ADDR;
  localparam logic [31:0] own_a  = `OWN_SLAVE_ADDRESS_ADDR;
  localparam logic [31:0] ds_a   = `DATA_SHIFT_REG_ADDR;
  logic        clk;
  logic        rst_b;
  logic [31:0] addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_r;
  logic        scl_oe;
  logic        sda_oe;
  logic        p_oe;
  logic        p_ack;
  logic        p_jam;
  logic        irq;
  logic [1:0]  drv;
  logic [31:0] d;
  logic [8:0]  b;
  int          per;
  int          n_fail = 0;
  int          n_checks = 0;
  wire         scl_w = ~scl_oe;
  wire         sda_w = ~(sda_oe | p_oe);

  i2c_control_status_regs DUT (.core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_r), .scl_i(scl_w), .scl_o(drv[1]), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(drv[0]), .sda_oe_o(sda_oe), .irq_o(irq));
  twi_slave_model u_slave (.core_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl_w), .sda_i(sda_w),
    .ack_i(p_ack), .jam_i(p_jam), .sda_oe_o(p_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus and line helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v,
                     output logic [31:0] r);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wait_r !== 1'b0) @(posedge clk);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task automatic get_byte(output logic [8:0] bits, output int per_c);
    int t;
    int n;
    int t0;
    logic p;
    begin
      n = 0;
      t0 = 0;
      per_c = 0;
      bits = 9'h000;
      p = scl_w;
      for (t = 0; t < 8000 && n < 9; t++) begin
        @(negedge clk);
        if (scl_w && !p) begin
          bits = {bits[7:0], sda_w};
          if (n == 1) per_c = t - t0;
          t0 = t;
          n++;
        end
        p = scl_w;
      end
      if (n < 9) n_fail++;
    end
  endtask
  task automatic wait_irq;
    int k;
    for (k = 0; k < 8000 && irq !== 1'b1; k++) @(negedge clk);
    if (irq !== 1'b1) n_fail++;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    int m;
    begin
      bus(0, con_a, 32'h0, d);
      `CHK("con_flags", 4'h0, d[7:4])
      bus(0, stat_a, 32'h0, d);
      `CHK("status", 8'h00, d[7:0])
      bus(1, con_a, 32'h0000_00F3, d);
      bus(0, con_a, 32'h0, d);
      `CHK("con_rw", 8'hE3, d[7:0])
      bus(1, own_a, 32'h0000_0054, d);
      bus(1, ds_a, 32'h0000_0077, d);
      bus(0, own_a, 32'h0, d);
      `CHK("own_off", 8'h54, d[7:0])
      bus(0, ds_a, 32'h0, d);
      `CHK("ds_off", 8'h00, d[7:0])
      for (m = 0; m < 4; m++) begin
        bus(1, stat_a, {24'h00_0000, m[1:0], 6'h10}, d);
        bus(0, stat_a, 32'h0, d);
        `CHK("mode", {m[1:0], 6'h10}, d[7:0])
      end
      bus(1, stat_a, 32'h0000_0010, d);
      bus(1, own_a, 32'h0000_0022, d);
      bus(0, own_a, 32'h0, d);
      `CHK("own_on", 8'h54, d[7:0])
      bus(1, ds_a, 32'h0000_0077, d);
      bus(0, ds_a, 32'h0, d);
      `CHK("ds_on", 8'h77, d[7:0])
      bus(1, 32'h5400_0010, 32'h0000_00FF, d);
      bus(0, 32'h5400_0010, 32'h0, d);
      `CHK("unmapped", 32'h0, d)
    end
  endtask
  task automatic t_master_tx;
    bus(1, con_a, 32'h0000_00A2, d);
    bus(1, ds_a, 32'h0000_00A0, d);
    p_ack <= 1'b1;
    bus(1, stat_a, 32'h0000_00F0, d);
    get_byte(b, per);
    `CHK("byte1", 9'h140, b)
    `CHK("period16", 48, per)
    wait_irq;
    `CHK("irq", 1'b1, irq)
    repeat (40) @(negedge clk);
    `CHK("scl_held", 1'b0, scl_w)
    bus(0, stat_a, 32'h0, d);
    `CHK("stat_ack", 8'hF0, d[7:0])
    bus(1, ds_a, 32'h0000_005B, d);
    p_ack <= 1'b0;
    bus(1, con_a, 32'h0000_0060, d);
    get_byte(b, per);
    `CHK("byte2", 9'h0B7, b)
    `CHK("period512", 512, per)
    wait_irq;
    bus(0, stat_a, 32'h0, d);
    `CHK("stat_nack", 8'hF1, d[7:0])
    bus(1, stat_a, 32'h0000_00D0, d);
    bus(1, con_a, 32'h0000_0060, d);
    repeat (1000) @(negedge clk);
    bus(0, stat_a, 32'h0, d);
    `CHK("busy_off", 1'b0, d[5])
    `CHK("lines_free", 2'b11, {scl_w, sda_w})
  endtask
  task automatic t_arb;
    bus(1, con_a, 32'h0000_00A2, d);
    bus(1, ds_a, 32'h0000_00FF, d);
    bus(1, stat_a, 32'h0000_00F0, d);
    repeat (4) @(posedge clk);
    p_jam <= 1'b1;
    wait_irq;
    bus(0, stat_a, 32'h0, d);
    `CHK("arb_lost", 3'b001, {d[7:6], d[3]})
    p_jam <= 1'b0;
    bus(1, con_a, 32'h0000_0092, d);
    @(negedge clk);
    `CHK("irq_masked", 1'b0, irq)
    bus(0, con_a, 32'h0, d);
    `CHK("pend_kept", 1'b1, d[4])
    bus(1, stat_a, 32'h0000_0000, d);
    repeat (2) @(negedge clk);
    `CHK("released", 2'b00, {scl_oe, sda_oe})
    bus(1, con_a, 32'h0000_00A2, d);
  endtask
  task automatic t_master_rx;
    bus(1, stat_a, 32'h0000_0010, d);
    bus(1, ds_a, 32'h0000_00A1, d);
    bus(1, stat_a, 32'h0000_00B0, d);
    get_byte(b, per);
    wait_irq;
    bus(1, con_a, 32'h0000_00A2, d);
    get_byte(b, per);
    `CHK("rx_ack", 9'h1FE, b)
    `CHK("drive_lvl", 2'b00, drv)
    bus(0, ds_a, 32'h0, d);
    `CHK("rx_data", 8'hFF, d[7:0])
  endtask
  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #3_000_000;
    n_fail++;
    conclude;
  end
  initial begin
    rst_b = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    rd = 1'b0;
    wr = 1'b0;
    p_ack = 1'b0;
    p_jam = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_master_tx;
    t_arb;
    t_master_rx;
    conclude;
  end
endmodule
